// file: bench/cal_operator.sv
// Operator model that drives the calibration switch and the turn reports.
`timescale 1ns/1ns
`default_nettype none
module cal_operator (
    input  wire logic clk,
    output logic      sw,
    output logic      turn,
    output logic      data_ok
);
    // The switch starts ON so that power-up runs the erase path.
    initial begin
        sw = 1'b1;
        turn = 1'b0;
        data_ok = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic set_sw(input logic v);
        @(posedge clk);
        sw <= v;
        repeat (3) @(posedge clk);
    endtask
    // The adequacy flag has no meaning away from a turn, so it flips there.
    task automatic do_turn(input logic ok);
        @(posedge clk);
        turn <= 1'b1;
        data_ok <= ok;
        @(posedge clk);
        turn <= 1'b0;
        data_ok <= ~ok;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the attitude status and calibration block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import attitude_status_pkg::*;
    localparam logic [31:0] N_INIT = 32'd50;
    logic               clk, rst_n, wr, rd, sw, turn, ok, erase, apply, store, irq;
    logic [3:0]         addr;
    logic [31:0]        wdata, rdata;
    logic [15:0]        st;
    int                 fails = 0, checks_done = 0, n_er = 0, n_ap = 0, n_st = 0;
    int                 k[4] = '{3840, 46080, 307200, 480};
    logic signed [15:0] raw[2] = '{-16'sd12345, 16'sd32767};
    longint             p;

    cal_operator op (.clk(clk), .sw(sw), .turn(turn), .data_ok(ok));
    attitude_status_calibration #(.INIT_COUNT(N_INIT)) uut (
        .REF_CLK(clk), .ARST_N(rst_n), .CAL_SWITCH(sw), .TURN_DONE(turn),
        .CAL_DATA_OK(ok), .CAL_ERASE(erase), .CAL_APPLY(apply), .CAL_STORE(store),
        .STATUS_WORD(st), .IRQ(irq), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Strobes are counted so that a missing or doubled pulse shows up.
    always @(posedge clk) begin
        n_er <= n_er + int'(erase);
        n_ap <= n_ap + int'(apply);
        n_st <= n_st + int'(store);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // A status that never arrives ends the run instead of hanging it.
    task automatic wait_st(input logic [15:0] exp, input int n);
        for (int i = 0; i < n; i++) begin
            #1;
            if (st === exp) break;
            @(posedge clk);
        end
        #1;
        chk(32'(st), 32'(exp));
        if (st !== exp) summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_st(16'h2400, 4);
        op.set_sw(1'b0);
        chk(32'(n_er), 32'd1);
        wr_reg(A_IRQ_EN, 32'hf);
        rd_reg(A_IRQ_EN, 32'hf);
        rd_reg(4'hf, 32'h0);
        chk(32'(st), 32'h2400);
        wait_st(16'h2000, 80);
        rd_reg(A_IRQ_ST, 32'h1);
        chk(32'(irq), 32'h1);
        wr_reg(A_IRQ_CLR, 32'h1);
        rd_reg(A_IRQ_ST, 32'h0);
        chk(32'(irq), 32'h0);
        op.do_turn(1'b1);
        chk(32'(n_ap), 32'd0);
        op.set_sw(1'b1);
        wait_st(16'h2800, 4);
        op.do_turn(1'b0);
        wait_st(16'h2c00, 4);
        repeat (10) @(posedge clk);
        op.do_turn(1'b1);
        wait_st(16'h0c00, 4);
        chk(32'(n_ap), 32'd2);
        repeat (46) @(posedge clk);
        #1;
        chk(32'(st), 32'h0c00);
        wait_st(16'h0800, 12);
        op.set_sw(1'b0);
        wait_st(16'h0000, 4);
        chk(32'(n_st), 32'd1);
        rd_reg(A_IRQ_ST, 32'hf);
        wr_reg(A_IRQ_CLR, 32'hf);
        rd_reg(A_IRQ_ST, 32'h0);
        chk(32'(irq), 32'h0);
        for (int q = 0; q < 4; q++) begin
            wr_reg(A_SCALE_SEL, 32'(q));
            foreach (raw[j]) begin
                p = (longint'(raw[j]) * k[q]) >>> 15;
                wr_reg(A_RAW, 32'(raw[j]));
                rd_reg(A_RAW, 32'(raw[j]));
                rd_reg(A_PHYS_LO, p[31:0]);
                rd_reg(A_PHYS_HI, p[63:32]);
            end
        end
        // A second reset with the switch off must restart init without an erase.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_st(16'h2400, 4);
        rd_reg(A_IRQ_EN, 32'h0);
        rd_reg(A_RAW, 32'h0);
        rd_reg(A_PHYS_LO, 32'h0);
        chk(32'(n_er), 32'd1);
        summarize();
    end
endmodule
`default_nettype wire

// file: core/attitude_status_calibration.sv
// Status word, calibration control and output scaling for the attitude unit.
//
// Functional notes
// R1: Output words are signed 16-bit two's complement.
// R2: Acceleration g equals word*10*1.5/2^15.
// R3: Accelerometer default range 10 g is scale.
// R4: Angle degrees equal word*180/2^15.
// R5: Rate deg/s equals word*800*1.5/2^15.
// R6: Field gauss equals word*1.25*1.5/2^15.
// R7: Calibration switch level enters magnetometer calibration; the code enters only on a switch rise after boot.
// R8: Switch set at power-up erases calibration.
// R9: Device decides data adequacy, reports in status.
// R10: Status bits 10:9 encode attitude state.
// R11: Status bit 11 shows calibration mode.
// R12: Status bit 13 reports calibration data status.
// R13: Initialization lasts 90 seconds, then ready.
// R14: Initializing reads 2'b10, ready reads 2'b00.
// R15: Full turn restarts initialization, applies parameters.
// R16: Switch release stores constants to nonvolatile memory.
// R17: Bit 13 clear means data adequate.
// R18: Init counter restarts on each re-initialization.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module attitude_status_calibration
    import attitude_status_pkg::*;
#(
    parameter logic [31:0] INIT_COUNT = attitude_status_pkg::INIT_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic        CAL_SWITCH,
    input  wire logic        TURN_DONE,
    input  wire logic        CAL_DATA_OK,
    output logic             CAL_ERASE,
    output logic             CAL_APPLY,
    output logic             CAL_STORE,
    output logic [15:0]      STATUS_WORD,
    output logic             IRQ,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA
);
    import attitude_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {S_BOOT, S_INIT, S_READY} alg_e;

    alg_e        state_q;
    logic [31:0] cnt_q;
    logic        cal_mode_q;
    logic        data_need_q;
    logic        sw_q;
    logic        erase_q, apply_q, store_q;
    logic [N_IRQ-1:0] irq_st_q, irq_en_q;
    wire logic [N_IRQ-1:0] irq_ev;
    logic [1:0]  sel_q;
    logic signed [15:0] raw_q;
    logic signed [47:0] phys_q;
    logic [31:0] rdata_q;
    logic [15:0] status_q;

    wire init_done = (state_q == S_INIT) && (cnt_q == INIT_COUNT - 32'h1);
    wire cal_enter = CAL_SWITCH && !sw_q && (state_q != S_BOOT);
    wire cal_leave = !CAL_SWITCH && sw_q && cal_mode_q;
    wire turn_ev   = cal_mode_q && TURN_DONE;
    wire [1:0] alg_code = (state_q == S_READY) ? ALG_READY : ALG_INIT;

    ////////////////////////////////////////////////////////////////////////////
    // Attitude state and init timer. Leaving boot one cycle after reset gives the
    // strap check for the erase a clean, clocked sample of the switch.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= S_BOOT;
            cnt_q   <= 32'h0;
        end else begin
            unique case (state_q)
                S_BOOT: begin
                    state_q <= S_INIT;
                    cnt_q   <= 32'h0;
                end
                S_INIT: begin
                    if (turn_ev) begin
                        cnt_q <= 32'h0; // R15 R18
                    end else if (init_done) begin
                        state_q <= S_READY; // R13
                    end else begin
                        cnt_q <= cnt_q + 32'h1; // R18
                    end
                end
                S_READY: begin
                    if (turn_ev) begin
                        state_q <= S_INIT; // R15
                        cnt_q   <= 32'h0; // R18
                    end
                end
            endcase
        end
    end

    // Calibration mode, data-status flag and one-cycle action strobes.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sw_q        <= 1'b0;
            cal_mode_q  <= 1'b0;
            data_need_q <= 1'b1;
            erase_q     <= 1'b0;
            apply_q     <= 1'b0;
            store_q     <= 1'b0;
        end else begin
            sw_q    <= CAL_SWITCH;
            erase_q <= (state_q == S_BOOT) && CAL_SWITCH; // R8
            apply_q <= turn_ev; // R15
            store_q <= cal_leave; // R16
            if (cal_enter) begin
                cal_mode_q  <= 1'b1; // R7
                data_need_q <= 1'b1;
            end else if (cal_leave) begin
                cal_mode_q <= 1'b0;
            end
            if (turn_ev) begin
                data_need_q <= !CAL_DATA_OK; // R9 R17
            end
        end
    end

    assign CAL_ERASE = erase_q;
    assign CAL_APPLY = apply_q;
    assign CAL_STORE = store_q;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_q <= 16'h0;
        end else begin
            status_q <= 16'h0;
            status_q[ST_ALG_HI:ST_ALG_LO] <= alg_code; // R10 R14
            status_q[ST_CAL_MODE] <= cal_mode_q; // R11
            status_q[ST_CAL_DATA] <= data_need_q; // R12 R17
        end
    end
    assign STATUS_WORD = status_q;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a same-cycle clear.
    assign irq_ev[IRQ_READY]     = init_done;
    assign irq_ev[IRQ_CAL_ENTER] = cal_enter;
    assign irq_ev[IRQ_TURN]      = turn_ev;
    assign irq_ev[IRQ_STORE]     = cal_leave;
    wire wr_clr = WR && (ADDR == A_IRQ_CLR);

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~(wr_clr ? WDATA[N_IRQ-1:0] : '0)) | irq_ev;
        end
    end
    assign IRQ = |(irq_st_q & irq_en_q);

    ////////////////////////////////////////////////////////////////////////////
    // Scaling: result is Q8 fixed point of the physical unit, truncated toward
    // minus infinity; one LSB of the result is 1/256 of the unit.
    logic signed [47:0] prod;
    always_comb begin
        unique case (quantity_e'(sel_q))
            Q_ACC:   prod = 48'(raw_q * 3 * ACC_RANGE_G) <<< SCALE_FRAC; // R2 R3
            Q_ANGLE: prod = 48'(raw_q * 2 * ANGLE_RANGE_DEG) <<< SCALE_FRAC; // R4
            Q_RATE:  prod = 48'(raw_q * 3 * GYRO_RANGE_DPS) <<< SCALE_FRAC; // R5
            Q_MAG:   prod = (48'(raw_q * 3 * MAG_NUM_X100) <<< SCALE_FRAC) / 100; // R6
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phys_q <= '0;
        end else begin
            phys_q <= prod >>> (SCALE_SHIFT + 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_en_q <= '0;
            sel_q    <= 2'h0;
            raw_q    <= 16'sh0;
        end else if (WR) begin
            if (ADDR == A_IRQ_EN) irq_en_q <= WDATA[N_IRQ-1:0];
            if (ADDR == A_SCALE_SEL) sel_q <= WDATA[1:0];
            if (ADDR == A_RAW) raw_q <= WDATA[WORD_W-1:0]; // R1
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (ADDR)
            A_STATUS:    rd_mux = {16'h0, status_q};
            A_IRQ_ST:    rd_mux = {28'h0, irq_st_q};
            A_IRQ_EN:    rd_mux = {28'h0, irq_en_q};
            A_SCALE_SEL: rd_mux = {30'h0, sel_q};
            A_RAW:       rd_mux = {{16{raw_q[15]}}, raw_q}; // R1
            A_PHYS_LO:   rd_mux = phys_q[31:0];
            A_PHYS_HI:   rd_mux = {{16{phys_q[47]}}, phys_q[47:32]};
            default:     rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= RD ? rd_mux : 32'h0;
        end
    end
    assign RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    property p_ready_after_init;
        @(posedge REF_CLK) disable iff (!ARST_N)
        init_done && !turn_ev |=> state_q == S_READY;
    endproperty
    a_ready_after_init: assert property (p_ready_after_init) else $error("ready not reached"); // R13

    property p_turn_reinit;
        @(posedge REF_CLK) disable iff (!ARST_N)
        turn_ev |=> state_q == S_INIT && cnt_q == 32'h0 ##1 STATUS_WORD[10:9] == ALG_INIT;
    endproperty
    a_turn_reinit: assert property (p_turn_reinit) else $error("turn did not reinit"); // R15 R18

    property p_code;
        @(posedge REF_CLK) disable iff (!ARST_N)
        state_q == S_READY |=> STATUS_WORD[10:9] == 2'h0;
    endproperty
    a_code: assert property (p_code) else $error("ready code wrong"); // R14

    property p_cal_bit;
        @(posedge REF_CLK) disable iff (!ARST_N)
        cal_enter |=> ##1 STATUS_WORD[11];
    endproperty
    a_cal_bit: assert property (p_cal_bit) else $error("cal bit missing"); // R7 R11

    property p_store;
        @(posedge REF_CLK) disable iff (!ARST_N)
        cal_leave |=> CAL_STORE ##1 !CAL_STORE && !STATUS_WORD[11];
    endproperty
    a_store: assert property (p_store) else $error("store pulse wrong"); // R16

    property p_data;
        @(posedge REF_CLK) disable iff (!ARST_N)
        turn_ev && CAL_DATA_OK |=> ##1 !STATUS_WORD[13];
    endproperty
    a_data: assert property (p_data) else $error("data bit wrong"); // R9 R12 R17

    property p_erase;
        @(posedge REF_CLK) disable iff (!ARST_N)
        CAL_ERASE |-> $past(state_q) == S_BOOT && $past(CAL_SWITCH);
    endproperty
    a_erase: assert property (p_erase) else $error("erase out of boot"); // R8

    property p_irq;
        @(posedge REF_CLK) disable iff (!ARST_N)
        irq_ev[IRQ_TURN] && irq_en_q[IRQ_TURN] |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    // The strap is read only in boot, so a held switch gives exactly one erase pulse.
    sequence s_erase_pulse;
        CAL_ERASE ##1 !CAL_ERASE;
    endsequence

    property p_erase_strap;
        @(posedge REF_CLK) disable iff (!ARST_N)
        state_q == S_BOOT && CAL_SWITCH |=> s_erase_pulse;
    endproperty
    a_erase_strap: assert property (p_erase_strap) else $error("strap erase missing"); // R8

    property p_apply;
        @(posedge REF_CLK) disable iff (!ARST_N)
        turn_ev |=> CAL_APPLY;
    endproperty
    a_apply: assert property (p_apply) else $error("apply pulse missing"); // R15

    property p_apply_only;
        @(posedge REF_CLK) disable iff (!ARST_N)
        CAL_APPLY |-> $past(turn_ev);
    endproperty
    a_apply_only: assert property (p_apply_only) else $error("apply without turn"); // R15

    property p_init_code;
        @(posedge REF_CLK) disable iff (!ARST_N)
        state_q == S_INIT |=> STATUS_WORD[ST_ALG_HI:ST_ALG_LO] == ALG_INIT;
    endproperty
    a_init_code: assert property (p_init_code) else $error("init code wrong"); // R10 R14

    property p_cal_clear;
        @(posedge REF_CLK) disable iff (!ARST_N)
        !cal_mode_q |=> !STATUS_WORD[ST_CAL_MODE];
    endproperty
    a_cal_clear: assert property (p_cal_clear) else $error("cal bit set outside cal"); // R11

    property p_need_on_enter;
        @(posedge REF_CLK) disable iff (!ARST_N)
        cal_enter |=> ##1 STATUS_WORD[ST_CAL_DATA];
    endproperty
    a_need_on_enter: assert property (p_need_on_enter) else $error("data bit not set on entry"); // R12

    property p_timer_count;
        @(posedge REF_CLK) disable iff (!ARST_N)
        state_q == S_INIT && !turn_ev && !init_done |=> cnt_q == $past(cnt_q) + 32'h1;
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("init timer stalled"); // R18

    property p_rdata_idle;
        @(posedge REF_CLK) disable iff (!ARST_N)
        !RD |=> RDATA == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule
`default_nettype wire

// file: pkg/attitude_status_pkg.sv
// Constants for the attitude status and calibration block.
`default_nettype none
package attitude_status_pkg;
    localparam int unsigned REF_CLK_HZ = 20000000;
    localparam int unsigned INIT_TIME_S = 90;
    localparam longint unsigned INIT_CYCLES_L = longint'(INIT_TIME_S) * longint'(REF_CLK_HZ);
    localparam logic [31:0] INIT_CYCLES = INIT_CYCLES_L[31:0];
    localparam int unsigned WORD_W = 16;
    // Scale numerators over 2^15; the 1.5 factor is applied as *3/2.
    localparam int ACC_RANGE_G = 10;
    localparam int GYRO_RANGE_DPS = 800;
    localparam int ANGLE_RANGE_DEG = 180;
    localparam int MAG_NUM_X100 = 125;
    localparam int SCALE_SHIFT = 15;
    localparam int SCALE_FRAC = 8;
    // Status word layout.
    localparam int ST_ALG_LO = 9;
    localparam int ST_ALG_HI = 10;
    localparam int ST_CAL_MODE = 11;
    localparam int ST_CAL_DATA = 13;
    localparam logic [1:0] ALG_INIT = 2'h2;
    localparam logic [1:0] ALG_READY = 2'h0;
    // Register offsets.
    localparam logic [3:0] A_STATUS = 4'h0;
    localparam logic [3:0] A_IRQ_ST = 4'h1;
    localparam logic [3:0] A_IRQ_EN = 4'h2;
    localparam logic [3:0] A_IRQ_CLR = 4'h3;
    localparam logic [3:0] A_SCALE_SEL = 4'h4;
    localparam logic [3:0] A_RAW = 4'h5;
    localparam logic [3:0] A_PHYS_LO = 4'h6;
    localparam logic [3:0] A_PHYS_HI = 4'h7;
    localparam int N_IRQ = 4;
    localparam int IRQ_READY = 0;
    localparam int IRQ_CAL_ENTER = 1;
    localparam int IRQ_TURN = 2;
    localparam int IRQ_STORE = 3;
    typedef enum logic [1:0] {Q_ACC, Q_ANGLE, Q_RATE, Q_MAG} quantity_e;
endpackage
`default_nettype wire
